// [hdl/asis_top.sv]
// Sequence input select register with AXI4-Lite slave and slot routing.
// Assumes the sequencer pulses i_conv_start with the slot index it runs.
//
// What this block does
// - Bits 30:28 select input for slot eight
// - Bits 26:24 select input for slot seven
// - Bits 22:20 select input for slot six
// - Bits 18:16 select input for slot five
// - Bits 14:12 select input for slot four
// - Bits 10:8 select input for slot three
// - Bits 6:4 select input for slot two
// - Bits 2:0 select input for slot one
// - Fields read/write, reset to zero
// - Gap bits read zero; software preserves them
// - One 32-bit register, eight slot fields
// - Temp sensor bit overrides the pin field
`timescale 1ns/1ps
`default_nettype none

module asis_top (
    input wire logic i_clk,                                // 125 MHz clock
    input wire logic i_rst_n,                              // Async reset, active low
    // AXI4-Lite write address
    input wire logic i_s_axil_awvalid,                     // Address valid
    output logic o_s_axil_awready,                         // Address ready
    input wire logic [asis_pkg::ASIS_ADDR_W-1:0] i_s_axil_awaddr, // Write address
    input wire logic [2:0] i_s_axil_awprot,                // Ignored
    // AXI4-Lite write data
    input wire logic i_s_axil_wvalid,                      // Data valid
    output logic o_s_axil_wready,                          // Data ready
    input wire logic [31:0] i_s_axil_wdata,                // Write data
    input wire logic [3:0] i_s_axil_wstrb,                 // Byte strobes
    // AXI4-Lite write response
    output logic o_s_axil_bvalid,                          // Response valid
    input wire logic i_s_axil_bready,                      // Response ready
    output logic [1:0] o_s_axil_bresp,                     // Response code
    // AXI4-Lite read address
    input wire logic i_s_axil_arvalid,                     // Address valid
    output logic o_s_axil_arready,                         // Address ready
    input wire logic [asis_pkg::ASIS_ADDR_W-1:0] i_s_axil_araddr, // Read address
    input wire logic [2:0] i_s_axil_arprot,                // Ignored
    // AXI4-Lite read data
    output logic o_s_axil_rvalid,                          // Read valid
    input wire logic i_s_axil_rready,                      // Read ready
    output logic [31:0] o_s_axil_rdata,                    // Read data
    output logic [1:0] o_s_axil_rresp,                     // Read response
    // Sequencer side
    input wire logic i_conv_start,                         // Slot conversion start pulse
    input wire logic [asis_pkg::ASIS_SLOT_W-1:0] i_slot_idx, // Slot being converted
    output logic [asis_pkg::ASIS_FIELD_W-1:0] o_ain_sel,   // Analog input index
    output logic o_ain_route_en,                           // Analog input routed
    output logic o_temp_route_en,                          // Temp sensor routed
    output logic o_sel_valid                               // Selection updated pulse
);
    import asis_pkg::*;

    // Write channel state
    asis_wr_state_e wr_state_ff, nxt_wr_state;
    logic aw_held_ff, nxt_aw_held;
    logic w_held_ff, nxt_w_held;
    logic [ASIS_ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;

    // Read channel state
    asis_rd_state_e rd_state_ff, nxt_rd_state;
    logic arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    // Register bank
    logic [31:0] sel_ff, nxt_sel;
    logic [ASIS_NSLOT-1:0] ts_ff, nxt_ts;

    // Write beat resolved from held or live channel values
    logic aw_now, w_now, wr_fire;
    logic [ASIS_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] sel_merged, ts_merged;
    logic [ASIS_FIELD_W-1:0] pick_ain;
    logic [ASIS_SLOT_W-1:0] pick_slot;
    logic pick_ain_en, pick_temp_en, pick_valid;
    logic [31:0] stat_word;

    assign aw_now = aw_held_ff | (i_s_axil_awvalid & awready_ff);
    assign w_now = w_held_ff | (i_s_axil_wvalid & wready_ff);
    assign wr_fire = (wr_state_ff == ASIS_WR_IDLE) & aw_now & w_now;
    assign wr_addr = aw_held_ff ? awaddr_ff : i_s_axil_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : i_s_axil_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : i_s_axil_wstrb;

    asis_lane_merge u_sel_merge (
        .i_old(sel_ff),
        .i_new(wr_data),
        .i_strb(wr_strb),
        .i_wmask(ASIS_SEL_WMASK),
        .o_merged(sel_merged)
    );

    asis_lane_merge u_ts_merge (
        .i_old({24'h00_0000, ts_ff}),
        .i_new(wr_data),
        .i_strb(wr_strb),
        .i_wmask(ASIS_TS_WMASK),
        .o_merged(ts_merged)
    );

    // Write address and data taken in either order
    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        unique case (wr_state_ff)
            ASIS_WR_IDLE: begin
                if (wr_fire) begin
                    nxt_wr_state = ASIS_WR_RESP;
                    nxt_aw_held = 1'b0;
                    nxt_w_held = 1'b0;
                    nxt_awready = 1'b0;
                    nxt_wready = 1'b0;
                    nxt_bvalid = 1'b1;
                    if (wr_addr[ASIS_ADDR_W-1:2] == ASIS_SEL_OFFSET[ASIS_ADDR_W-1:2] ||
                        wr_addr[ASIS_ADDR_W-1:2] == ASIS_TS_OFFSET[ASIS_ADDR_W-1:2] ||
                        wr_addr[ASIS_ADDR_W-1:2] == ASIS_STAT_OFFSET[ASIS_ADDR_W-1:2]) begin
                        nxt_bresp = ASIS_RESP_OKAY;
                    end else begin
                        nxt_bresp = ASIS_RESP_SLVERR;
                    end
                end else begin
                    if (i_s_axil_awvalid && awready_ff) begin
                        nxt_aw_held = 1'b1;
                        nxt_awaddr = i_s_axil_awaddr;
                        nxt_awready = 1'b0;
                    end
                    if (i_s_axil_wvalid && wready_ff) begin
                        nxt_w_held = 1'b1;
                        nxt_wdata = i_s_axil_wdata;
                        nxt_wstrb = i_s_axil_wstrb;
                        nxt_wready = 1'b0;
                    end
                end
            end
            ASIS_WR_RESP: begin
                if (i_s_axil_bready) begin
                    nxt_wr_state = ASIS_WR_IDLE;
                    nxt_bvalid = 1'b0;
                    nxt_awready = 1'b1;
                    nxt_wready = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_state_ff <= ASIS_WR_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= ASIS_RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    // Register bank; status word is read-only
    always_comb begin
        nxt_sel = sel_ff;
        nxt_ts = ts_ff;
        if (wr_fire && wr_addr[ASIS_ADDR_W-1:2] == ASIS_SEL_OFFSET[ASIS_ADDR_W-1:2]) begin
            nxt_sel = sel_merged;
        end
        if (wr_fire && wr_addr[ASIS_ADDR_W-1:2] == ASIS_TS_OFFSET[ASIS_ADDR_W-1:2]) begin
            nxt_ts = ts_merged[ASIS_NSLOT-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_ff <= ASIS_SEL_RESET;
            ts_ff <= ASIS_TS_RESET;
        end else begin
            sel_ff <= nxt_sel;
            ts_ff <= nxt_ts;
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ASIS_STAT_SLOT_LSB +: ASIS_SLOT_W] = pick_slot;
        stat_word[ASIS_STAT_AIN_LSB +: ASIS_FIELD_W] = pick_ain;
        stat_word[ASIS_STAT_AIN_EN_BIT] = pick_ain_en;
        stat_word[ASIS_STAT_TEMP_BIT] = pick_temp_en;
    end

    // Read channel: data registered one cycle after address taken
    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        unique case (rd_state_ff)
            ASIS_RD_IDLE: begin
                if (i_s_axil_arvalid && arready_ff) begin
                    nxt_rd_state = ASIS_RD_DATA;
                    nxt_arready = 1'b0;
                    nxt_rvalid = 1'b1;
                    nxt_rresp = ASIS_RESP_OKAY;
                    if (i_s_axil_araddr[ASIS_ADDR_W-1:2] == ASIS_SEL_OFFSET[ASIS_ADDR_W-1:2]) begin
                        nxt_rdata = sel_ff & ASIS_SEL_WMASK;
                    end else if (i_s_axil_araddr[ASIS_ADDR_W-1:2] ==
                                 ASIS_TS_OFFSET[ASIS_ADDR_W-1:2]) begin
                        nxt_rdata = {24'h00_0000, ts_ff};
                    end else if (i_s_axil_araddr[ASIS_ADDR_W-1:2] ==
                                 ASIS_STAT_OFFSET[ASIS_ADDR_W-1:2]) begin
                        nxt_rdata = stat_word;
                    end else begin
                        nxt_rdata = 32'h0000_0000;
                        nxt_rresp = ASIS_RESP_SLVERR;
                    end
                end
            end
            ASIS_RD_DATA: begin
                if (i_s_axil_rready) begin
                    nxt_rd_state = ASIS_RD_IDLE;
                    nxt_rvalid = 1'b0;
                    nxt_arready = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_state_ff <= ASIS_RD_IDLE;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= ASIS_RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // Slot routing toward the converter mux
    asis_slot_pick u_pick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sel_reg(sel_ff),
        .i_ts(ts_ff),
        .i_start(i_conv_start),
        .i_slot(i_slot_idx),
        .o_ain(pick_ain),
        .o_ain_en(pick_ain_en),
        .o_temp_en(pick_temp_en),
        .o_valid(pick_valid),
        .o_slot(pick_slot)
    );

    assign o_s_axil_awready = awready_ff;
    assign o_s_axil_wready = wready_ff;
    assign o_s_axil_bvalid = bvalid_ff;
    assign o_s_axil_bresp = bresp_ff;
    assign o_s_axil_arready = arready_ff;
    assign o_s_axil_rvalid = rvalid_ff;
    assign o_s_axil_rdata = rdata_ff;
    assign o_s_axil_rresp = rresp_ff;
    assign o_ain_sel = pick_ain;
    assign o_ain_route_en = pick_ain_en;
    assign o_temp_route_en = pick_temp_en;
    assign o_sel_valid = pick_valid;

endmodule

`default_nettype wire

// [common/asis_pkg.sv]
// Constants and types shared by the sequence input select block.
// Assumes a 32-bit AXI4-Lite register bus and an eight-slot sequencer.
`default_nettype none

package asis_pkg;

    localparam int ASIS_ADDR_W = 12;
    localparam int ASIS_DATA_W = 32;
    localparam int ASIS_NSLOT = 8;
    localparam int ASIS_FIELD_W = 3;
    localparam int ASIS_FIELD_PITCH = 4;
    localparam int ASIS_SLOT_W = 3;

    // Register byte offsets
    localparam logic [ASIS_ADDR_W-1:0] ASIS_SEL_OFFSET = 12'h040;
    localparam logic [ASIS_ADDR_W-1:0] ASIS_TS_OFFSET = 12'h044;
    localparam logic [ASIS_ADDR_W-1:0] ASIS_STAT_OFFSET = 12'h048;

    // Reset values and writable bit masks
    localparam logic [31:0] ASIS_SEL_RESET = 32'h0000_0000;
    localparam logic [7:0] ASIS_TS_RESET = 8'h00;
    localparam logic [31:0] ASIS_SEL_WMASK = 32'h7777_7777;
    localparam logic [31:0] ASIS_TS_WMASK = 32'h0000_00FF;

    // Status register field positions
    localparam int ASIS_STAT_SLOT_LSB = 0;
    localparam int ASIS_STAT_AIN_LSB = 4;
    localparam int ASIS_STAT_AIN_EN_BIT = 8;
    localparam int ASIS_STAT_TEMP_BIT = 9;

    localparam logic [1:0] ASIS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASIS_RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ASIS_WR_IDLE = 1'h0,
        ASIS_WR_RESP = 1'h1
    } asis_wr_state_e;

    typedef enum logic [0:0] {
        ASIS_RD_IDLE = 1'h0,
        ASIS_RD_DATA = 1'h1
    } asis_rd_state_e;

endpackage

`default_nettype wire

// [hdl/asis_lane_merge.sv]
// Byte-lane merge of a bus write into a register word.
// Assumes strobes as AXI4-Lite wstrb; masked bits always read zero.
`timescale 1ns/1ps
`default_nettype none

module asis_lane_merge (
    input wire logic [31:0] i_old,   // Current register value
    input wire logic [31:0] i_new,   // Write data
    input wire logic [3:0] i_strb,   // Byte strobes
    input wire logic [31:0] i_wmask, // Writable bits
    output logic [31:0] o_merged     // Next register value
);
    import asis_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            // Read-only bits forced to zero
            assign o_merged[g*8 +: 8] = (i_strb[g] ? i_new[g*8 +: 8] : i_old[g*8 +: 8])
                                        & i_wmask[g*8 +: 8];
        end
    endgenerate

endmodule

`default_nettype wire

// [hdl/asis_slot_pick.sv]
// Per-slot input selection: picks the active slot's field at conversion start.
// Assumes i_start is a one-cycle pulse with i_slot valid in that cycle.
`timescale 1ns/1ps
`default_nettype none

module asis_slot_pick (
    input wire logic i_clk,                         // System clock
    input wire logic i_rst_n,                       // Async reset, active low
    input wire logic [31:0] i_sel_reg,              // Input select word
    input wire logic [asis_pkg::ASIS_NSLOT-1:0] i_ts, // Temp sensor select per slot
    input wire logic i_start,                       // Slot conversion start
    input wire logic [asis_pkg::ASIS_SLOT_W-1:0] i_slot, // Slot index
    output logic [asis_pkg::ASIS_FIELD_W-1:0] o_ain, // Routed analog input
    output logic o_ain_en,                          // Analog input routed
    output logic o_temp_en,                         // Temp sensor routed
    output logic o_valid,                           // Selection updated pulse
    output logic [asis_pkg::ASIS_SLOT_W-1:0] o_slot // Last slot started
);
    import asis_pkg::*;

    logic [ASIS_FIELD_W-1:0] field [ASIS_NSLOT];
    logic [ASIS_FIELD_W-1:0] ain_ff, nxt_ain;
    logic ain_en_ff, nxt_ain_en;
    logic temp_en_ff, nxt_temp_en;
    logic valid_ff, nxt_valid;
    logic [ASIS_SLOT_W-1:0] slot_ff, nxt_slot;

    genvar g;
    generate
        for (g = 0; g < ASIS_NSLOT; g++) begin : g_field
            // Slot g uses bits 4g+2..4g
            // Low four slots likewise
            assign field[g] = i_sel_reg[g*ASIS_FIELD_PITCH +: ASIS_FIELD_W];
        end
    endgenerate

    always_comb begin
        nxt_ain = ain_ff;
        nxt_ain_en = ain_en_ff;
        nxt_temp_en = temp_en_ff;
        nxt_slot = slot_ff;
        nxt_valid = 1'b0;
        if (i_start) begin
            nxt_slot = i_slot;
            nxt_valid = 1'b1;
            if (i_ts[i_slot]) begin
                // Temp sensor replaces the pin
                nxt_ain = '0;
                nxt_ain_en = 1'b0;
                nxt_temp_en = 1'b1;
            end else begin
                nxt_ain = field[i_slot];
                nxt_ain_en = 1'b1;
                nxt_temp_en = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ain_ff <= '0;
            ain_en_ff <= 1'b0;
            temp_en_ff <= 1'b0;
            valid_ff <= 1'b0;
            slot_ff <= '0;
        end else begin
            ain_ff <= nxt_ain;
            ain_en_ff <= nxt_ain_en;
            temp_en_ff <= nxt_temp_en;
            valid_ff <= nxt_valid;
            slot_ff <= nxt_slot;
        end
    end

    assign o_ain = ain_ff;
    assign o_ain_en = ain_en_ff;
    assign o_temp_en = temp_en_ff;
    assign o_valid = valid_ff;
    assign o_slot = slot_ff;

endmodule

`default_nettype wire

// [bench/asis_top_sva.sv]
// Concurrent checks on the sequence input select block ports.
// Assumes it is bound into asis_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module asis_top_sva
    import asis_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_s_axil_awvalid, // AW valid
    input wire logic o_s_axil_awready, // AW ready
    input wire logic i_s_axil_wvalid, // W valid
    input wire logic o_s_axil_wready, // W ready
    input wire logic o_s_axil_bvalid, // B valid
    input wire logic i_s_axil_arvalid, // AR valid
    input wire logic o_s_axil_arready, // AR ready
    input wire logic [ASIS_ADDR_W-1:0] i_s_axil_araddr, // Read address
    input wire logic o_s_axil_rvalid, // R valid
    input wire logic [31:0] o_s_axil_rdata, // Read data
    input wire logic [1:0] o_s_axil_rresp, // Read response
    input wire logic i_conv_start, // Slot start
    input wire logic [ASIS_FIELD_W-1:0] o_ain_sel, // Analog input index
    input wire logic o_ain_route_en, // Pin routed
    input wire logic o_temp_route_en, // Temp sensor routed
    input wire logic o_sel_valid // Selection pulse
);
    logic [9:0] rd_word_ff;
    logic [9:0] nxt_rd_word;
    logic mapped;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Word address of the read being answered
    always_comb begin
        nxt_rd_word = rd_word_ff;
        if (i_s_axil_arvalid && o_s_axil_arready) begin
            nxt_rd_word = i_s_axil_araddr[11:2];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_word_ff <= 10'h000;
        end else begin
            rd_word_ff <= nxt_rd_word;
        end
    end

    assign mapped = (rd_word_ff >= 10'h010) && (rd_word_ff <= 10'h012);

    sel_pulse_a:
        assert property (i_conv_start |=> o_sel_valid) else $error("no selection pulse");
    sel_cause_a:
        assert property (o_sel_valid |-> $past(i_conv_start)) else $error("stray selection pulse");
    sel_hold_a:
        assert property (!i_conv_start |=> $stable(o_ain_sel) && $stable(o_ain_route_en)
            && $stable(o_temp_route_en)) else $error("selection moved without a start");
    route_one_a:
        assert property (o_sel_valid |-> o_ain_route_en ^ o_temp_route_en)
            else $error("route enables not exclusive");
    temp_zero_a:
        assert property (o_temp_route_en |-> !o_ain_route_en && o_ain_sel == 3'h0)
            else $error("pin routed beside temp sensor");
    b_after_w_a:
        assert property (i_s_axil_awvalid && o_s_axil_awready && i_s_axil_wvalid
            && o_s_axil_wready |=> o_s_axil_bvalid) else $error("write response late");
    aw_block_a:
        assert property (o_s_axil_bvalid |-> !o_s_axil_awready && !o_s_axil_wready)
            else $error("write taken while response pending");
    r_after_ar_a:
        assert property (i_s_axil_arvalid && o_s_axil_arready |=> o_s_axil_rvalid)
            else $error("read data late");
    sel_gaps_zero_a:
        assert property (o_s_axil_rvalid && rd_word_ff == 10'h010
            |-> (o_s_axil_rdata & ~ASIS_SEL_WMASK) == 32'h0000_0000)
            else $error("gap bits read nonzero");
    unmapped_err_a:
        assert property (o_s_axil_rvalid && !mapped
            |-> o_s_axil_rresp == ASIS_RESP_SLVERR && o_s_axil_rdata == 32'h0000_0000)
            else $error("unmapped read not refused");
endmodule

bind asis_top asis_top_sva chk_u (
    .i_clk, .i_rst_n, .i_s_axil_awvalid, .o_s_axil_awready, .i_s_axil_wvalid,
    .o_s_axil_wready, .o_s_axil_bvalid, .i_s_axil_arvalid, .o_s_axil_arready,
    .i_s_axil_araddr, .o_s_axil_rvalid, .o_s_axil_rdata, .o_s_axil_rresp,
    .i_conv_start, .o_ain_sel, .o_ain_route_en, .o_temp_route_en, .o_sel_valid
);

`default_nettype wire

// [bench/adc_sequence_input_select_tb_top.sv]
// Self-checking bench for the sequence input select block.
// Assumes asis_top with an AXI4-Lite slave and a slot start pulse input.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module adc_sequence_input_select_tb_top;
    import asis_pkg::*;

    logic i_clk = 1'b0;
    logic i_rst_n, i_s_axil_awvalid, i_s_axil_wvalid, i_s_axil_bready;
    logic i_s_axil_arvalid, i_s_axil_rready, i_conv_start;
    logic [11:0] i_s_axil_awaddr, i_s_axil_araddr;
    logic [31:0] i_s_axil_wdata, o_s_axil_rdata;
    logic [3:0] i_s_axil_wstrb;
    logic [2:0] i_slot_idx, o_ain_sel;
    logic o_s_axil_awready, o_s_axil_wready, o_s_axil_bvalid, o_s_axil_arready;
    logic o_s_axil_rvalid, o_ain_route_en, o_temp_route_en, o_sel_valid;
    logic [1:0] o_s_axil_bresp, o_s_axil_rresp;
    int n_fail = 0;
    int num_checks = 0;
    int cyc_cnt = 0;

    asis_top dut_u (
        .i_clk, .i_rst_n, .i_s_axil_awvalid, .o_s_axil_awready, .i_s_axil_awaddr,
        .i_s_axil_awprot(3'h0), .i_s_axil_wvalid, .o_s_axil_wready, .i_s_axil_wdata,
        .i_s_axil_wstrb, .o_s_axil_bvalid, .i_s_axil_bready, .o_s_axil_bresp,
        .i_s_axil_arvalid, .o_s_axil_arready, .i_s_axil_araddr, .i_s_axil_arprot(3'h0),
        .o_s_axil_rvalid, .i_s_axil_rready, .o_s_axil_rdata, .o_s_axil_rresp,
        .i_conv_start, .i_slot_idx, .o_ain_sel, .o_ain_route_en, .o_temp_route_en,
        .o_sel_valid
    );

    always #4 i_clk = ~i_clk;

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 110 cycles the tests need
    always @(posedge i_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e_resp);
        logic aw_left;
        logic w_left;
        @(posedge i_clk);
        i_s_axil_awvalid <= 1'b1;
        i_s_axil_awaddr <= a;
        i_s_axil_wvalid <= 1'b1;
        i_s_axil_wdata <= d;
        i_s_axil_wstrb <= s;
        i_s_axil_bready <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        while (aw_left || w_left) begin
            @(posedge i_clk);
            if (aw_left && o_s_axil_awready === 1'b1) begin
                i_s_axil_awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && o_s_axil_wready === 1'b1) begin
                i_s_axil_wvalid <= 1'b0;
                w_left = 1'b0;
            end
        end
        do @(posedge i_clk); while (o_s_axil_bvalid !== 1'b1);
        `CHK("bresp", e_resp, o_s_axil_bresp)
        i_s_axil_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e_d, input logic [1:0] e_resp);
        @(posedge i_clk);
        i_s_axil_arvalid <= 1'b1;
        i_s_axil_araddr <= a;
        i_s_axil_rready <= 1'b1;
        do @(posedge i_clk); while (o_s_axil_arready !== 1'b1);
        i_s_axil_arvalid <= 1'b0;
        do @(posedge i_clk); while (o_s_axil_rvalid !== 1'b1);
        `CHK("rdata", e_d, o_s_axil_rdata)
        `CHK("rresp", e_resp, o_s_axil_rresp)
        i_s_axil_rready <= 1'b0;
    endtask

    task automatic conv(input logic [2:0] k, input logic [2:0] e_sel, input logic e_ain,
                        input logic e_tmp);
        @(posedge i_clk);
        i_conv_start <= 1'b1;
        i_slot_idx <= k;
        @(posedge i_clk);
        i_conv_start <= 1'b0;
        #1;
        `CHK("sel_valid", 1'b1, o_sel_valid)
        `CHK("ain_sel", e_sel, o_ain_sel)
        `CHK("ain_route", e_ain, o_ain_route_en)
        `CHK("temp_route", e_tmp, o_temp_route_en)
    endtask

    initial begin
        i_rst_n = 1'b0;
        {i_s_axil_awvalid, i_s_axil_wvalid, i_s_axil_bready} = 3'h0;
        {i_s_axil_arvalid, i_s_axil_rready, i_conv_start} = 3'h0;
        {i_s_axil_awaddr, i_s_axil_araddr, i_s_axil_wdata} = 56'h0;
        i_s_axil_wstrb = 4'h0;
        i_slot_idx = 3'h0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(ASIS_SEL_OFFSET, 32'h0000_0000, ASIS_RESP_OKAY);
        rd(ASIS_TS_OFFSET, 32'h0000_0000, ASIS_RESP_OKAY);
        $display("test reset_values done");
        wr(ASIS_SEL_OFFSET, 32'hFFFF_FFFF, 4'hF, ASIS_RESP_OKAY);
        rd(ASIS_SEL_OFFSET, 32'h7777_7777, ASIS_RESP_OKAY);
        $display("test gap_bits done");
        wr(ASIS_SEL_OFFSET, 32'h0123_4567, 4'hF, ASIS_RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            conv(k[2:0], 3'(7 - k), 1'b1, 1'b0);
        end
        wr(ASIS_SEL_OFFSET, 32'h7654_3210, 4'hF, ASIS_RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            conv(k[2:0], k[2:0], 1'b1, 1'b0);
        end
        $display("test slot_fields done");
        wr(ASIS_SEL_OFFSET, 32'h0000_0000, 4'hF, ASIS_RESP_OKAY);
        wr(ASIS_SEL_OFFSET, 32'hFFFF_FFFF, 4'h2, ASIS_RESP_OKAY);
        rd(ASIS_SEL_OFFSET, 32'h0000_7700, ASIS_RESP_OKAY);
        $display("test byte_strobes done");
        wr(ASIS_SEL_OFFSET, 32'h0000_5000, 4'hF, ASIS_RESP_OKAY);
        wr(ASIS_TS_OFFSET, 32'h0000_0008, 4'hF, ASIS_RESP_OKAY);
        conv(3'h3, 3'h0, 1'b0, 1'b1);
        rd(ASIS_STAT_OFFSET, 32'h0000_0203, ASIS_RESP_OKAY);
        wr(ASIS_TS_OFFSET, 32'h0000_0000, 4'hF, ASIS_RESP_OKAY);
        conv(3'h3, 3'h5, 1'b1, 1'b0);
        $display("test temp_override done");
        rd(12'h100, 32'h0000_0000, ASIS_RESP_SLVERR);
        wr(12'h100, 32'hFFFF_FFFF, 4'hF, ASIS_RESP_SLVERR);
        rd(ASIS_SEL_OFFSET, 32'h0000_5000, ASIS_RESP_OKAY);
        $display("test unmapped done");
        wr(ASIS_SEL_OFFSET, 32'h1234_5670, 4'hF, ASIS_RESP_OKAY);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(ASIS_SEL_OFFSET, 32'h0000_0000, ASIS_RESP_OKAY);
        rd(ASIS_STAT_OFFSET, 32'h0000_0000, ASIS_RESP_OKAY);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
